// ### src/spk_pkg.sv
// package: register map, field positions, reset values and enumerations of the speakerphone control block
package spk_pkg;

    // ------------------------------------------------------------
    // register byte addresses (apb, one 32-bit word each)
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFFSET = 8'h00;       // control bits
    localparam logic [7:0] SEQ_CMD_OFFSET = 8'h04;    // start a parameter sequence
    localparam logic [7:0] SEQ_DATA_OFFSET = 8'h08;   // next parameter byte
    localparam logic [7:0] PARAM_SEL_OFFSET = 8'h0c;  // readback byte selector
    localparam logic [7:0] PARAM_DATA_OFFSET = 8'h10; // readback byte
    localparam logic [7:0] STATUS_OFFSET = 8'h14;     // live state

    // ------------------------------------------------------------
    // control field positions
    // ------------------------------------------------------------
    localparam int CTRL_SP_EN_BIT = 0;       // speakerphone_enable
    localparam int CTRL_RX_HP_DIS_BIT = 1;   // rx_highpass_disable
    localparam int CTRL_TX_HP_DIS_BIT = 2;   // tx_highpass_disable
    localparam int CTRL_PZ_TEST_BIT = 3;     // piezo_test_enable
    localparam int CTRL_TEST_SEL_BIT = 4;    // test_mode_select

    // status field positions
    localparam int STAT_MODE_LSB = 0;        // two bits of speakerphone mode
    localparam int STAT_POS_LSB = 2;         // four bits of sequence position
    localparam int STAT_SEQ_LSB = 6;         // three bits of selected sequence
    localparam int STAT_TX_LED_BIT = 9;      // transmit indicator
    localparam int STAT_IDLE_LED_BIT = 10;   // idle indicator

    // ------------------------------------------------------------
    // parameter sequences
    // ------------------------------------------------------------
    localparam logic [2:0] SEQ_COUNT = 3'h6;         // first, comparator, limits, decay, tx agc, rx agc
    localparam logic [3:0] SEQ_BYTES = 4'h8;         // byte positions per sequence
    localparam logic [2:0] SEQ_FIRST = 3'h0;         // first sequence index
    localparam logic [2:0] SEQ_TX_AGC = 3'h4;        // tx agc sequence index
    localparam logic [2:0] SEQ_RX_AGC = 3'h5;        // rx agc sequence index
    // positions holding a parameter; the rest are don't-care, one byte per sequence (first in low byte)
    localparam logic [47:0] USED_POS_MASK = {8'h7f, 8'h3f, 8'hff, 8'h7f, 8'hff, 8'hff};
    localparam logic [7:0] PARAM_RESET = 8'h00;      // reset value of every parameter byte

    // speakerphone switching state from the echo comparator
    typedef enum logic [1:0] {
        SP_RX = 2'b00,
        SP_TX = 2'b01,
        SP_IDLE = 2'b10
    } sp_mode_t;

endpackage

// ### src/sample_if.sv
// interface: one stream of 16-bit audio samples with a valid strobe
`timescale 1ns/1ps
interface sample_if;
    logic valid;               // one-cycle sample strobe
    logic signed [15:0] data;  // sample word
    modport src (output valid, output data);
    modport snk (input valid, input data);
endinterface

// ### src/highpass_filter.sv
// module: first-order dc-removing high-pass filter for a 16-bit sample stream
`timescale 1ns/1ps
module highpass_filter (
    input wire logic clk,
    input wire logic rst,
    input wire logic bypass,
    sample_if.snk in_s,
    sample_if.src out_s
);
    typedef struct packed {
        logic signed [23:0] acc;   // running dc estimate, 8 fraction bits
        logic valid;               // output strobe
        logic signed [15:0] data;  // output sample
    } hp_state_t;

    hp_state_t state_reg;
    hp_state_t state_next;
    logic signed [16:0] diff;      // sample minus dc estimate
    logic signed [15:0] clipped;   // difference saturated to 16 bits

    // ------------------------------------------------------------
    // next state: subtract dc estimate, let estimate track slowly
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        diff = 17'(in_s.data) - 17'(signed'(state_reg.acc[23:8]));
        if (diff > 17'sh07fff) begin
            clipped = 16'sh7fff;
        end else if (diff < -17'sh08000) begin
            clipped = -16'sh8000;
        end else begin
            clipped = diff[15:0];
        end
        state_next.valid = in_s.valid;
        if (in_s.valid) begin
            if (bypass) begin
                // filter disabled: sample passes unchanged, estimate frozen
                state_next.data = in_s.data;
            end else begin
                state_next.data = clipped;
                state_next.acc = state_reg.acc + 24'(diff);
            end
        end
    end

    // register the state
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign out_s.valid = state_reg.valid;
    assign out_s.data = state_reg.data;
endmodule // highpass_filter

// ### src/test_indicator.sv
// module: speakerphone test indicators on the two piezo driver pins
`timescale 1ns/1ps
module test_indicator (
    input wire logic clk,
    input wire logic rst,
    input wire logic piezo_test_enable,
    input wire logic test_mode_select,
    input wire spk_pkg::sp_mode_t mode_next,
    output logic tx_led,
    output logic idle_led
);
    import spk_pkg::*;

    typedef struct packed {
        logic via_tx;   // last non-idle mode was transmit
        logic tx_led;   // transmit indicator
        logic idle_led; // idle indicator
    } ind_state_t;

    ind_state_t state_reg;
    ind_state_t state_next;

    // ------------------------------------------------------------
    // indicators follow the next mode so they move with the state
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        // history is kept even with the test off, so it is right when enabled
        case (mode_next)
            SP_RX: state_next.via_tx = 1'b0;
            SP_TX: state_next.via_tx = 1'b1;
            default: state_next.via_tx = state_reg.via_tx;
        endcase
        if (piezo_test_enable && test_mode_select) begin
            case (mode_next)
                SP_RX: begin
                    state_next.tx_led = 1'b0;
                    state_next.idle_led = 1'b0;
                end
                SP_TX: begin
                    state_next.tx_led = 1'b1;
                    state_next.idle_led = 1'b0;
                end
                default: begin
                    state_next.idle_led = 1'b1;
                    state_next.tx_led = state_next.via_tx;
                end
            endcase
        end else begin
            state_next.tx_led = 1'b0;
            state_next.idle_led = 1'b0;
        end
    end

    // register the state at the same edge as the mode register
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign tx_led = state_reg.tx_led;
    assign idle_led = state_reg.idle_led;
endmodule // test_indicator

// ### src/speakerphone_param_load_and_test.sv
// module: apb control block for speakerphone parameter loading, filters, gain stages and test indicators
`timescale 1ns/1ps
module speakerphone_param_load_and_test (
    input wire logic clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // switching state from the echo comparator
    input wire logic [1:0] comparator_mode,
    // piezo driver pins carrying the test indicators
    output logic piezo_driver_pin_tx,
    output logic piezo_driver_pin_idle,
    // gain stages inside the automatic gain control
    output logic tx_agc_gain_stage_on,
    output logic rx_agc_gain_stage_on,
    output logic [7:0] tx_agc_gain_stage,
    output logic [7:0] rx_agc_gain_stage,
    // first parameter sequence, as applied
    output logic [7:0] acoustic_echo_gain,
    output logic [7:0] line_echo_gain,
    output logic [7:0] switchable_attenuation,
    output logic [7:0] acoustic_echo_time,
    output logic [7:0] line_echo_time,
    output logic [7:0] wait_time,
    output logic [7:0] decay_speed,
    output logic [7:0] switching_time,
    // transmit sample path
    input wire logic tx_sample_valid,
    input wire logic [15:0] tx_sample_in,
    output logic tx_filtered_valid,
    output logic [15:0] tx_filtered,
    // receive sample path
    input wire logic rx_sample_valid,
    input wire logic [15:0] rx_sample_in,
    output logic rx_filtered_valid,
    output logic [15:0] rx_filtered
);
    import spk_pkg::*;

    // ------------------------------------------------------------
    // state of the block
    // ------------------------------------------------------------
    typedef struct packed {
        logic pready;               // apb completion strobe
        logic pslverr;              // apb error answer
        logic [31:0] prdata;        // apb read data
        logic sp_en;                // speakerphone_enable
        logic rx_hp_dis;            // rx_highpass_disable
        logic tx_hp_dis;            // tx_highpass_disable
        logic pz_test_en;           // piezo_test_enable
        logic test_sel;             // test_mode_select
        logic [2:0] seq_sel;        // sequence being loaded
        logic [3:0] seq_pos;        // next byte position, 8 means complete
        logic [5:0] param_sel;      // readback selector
        logic [47:0][7:0] params;   // every parameter byte of every sequence
        sp_mode_t mode;             // speakerphone switching state
    } ctl_state_t;

    ctl_state_t state_reg;
    ctl_state_t state_next;

    logic setup_done;               // access phase seen, answer not yet given
    logic complete;                 // edge at which the master samples pready
    logic mapped;                   // address decodes to a register
    logic [31:0] read_word;         // read data for the current address
    logic [5:0] byte_index;         // sequence and position flattened
    logic ind_tx;                   // transmit indicator flop
    logic ind_idle;                 // idle indicator flop

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    assign setup_done = psel && penable && !state_reg.pready;
    assign complete = psel && penable && state_reg.pready;
    assign byte_index = {state_reg.seq_sel, state_reg.seq_pos[2:0]};

    // address decode and read mux
    always_comb begin
        mapped = 1'b1;
        read_word = 32'h0000_0000;
        case (paddr)
            CTRL_OFFSET: begin
                read_word[CTRL_SP_EN_BIT] = state_reg.sp_en;
                read_word[CTRL_RX_HP_DIS_BIT] = state_reg.rx_hp_dis;
                read_word[CTRL_TX_HP_DIS_BIT] = state_reg.tx_hp_dis;
                read_word[CTRL_PZ_TEST_BIT] = state_reg.pz_test_en;
                read_word[CTRL_TEST_SEL_BIT] = state_reg.test_sel;
            end
            SEQ_CMD_OFFSET: begin
                read_word[2:0] = state_reg.seq_sel;
            end
            SEQ_DATA_OFFSET: begin
                // write-only port; reads as zero
            end
            PARAM_SEL_OFFSET: begin
                read_word[5:0] = state_reg.param_sel;
            end
            PARAM_DATA_OFFSET: begin
                read_word[7:0] = (state_reg.param_sel < {SEQ_COUNT, 3'h0}) ? state_reg.params[state_reg.param_sel] : 8'h00;
            end
            STATUS_OFFSET: begin
                read_word[STAT_MODE_LSB +: 2] = state_reg.mode;
                read_word[STAT_POS_LSB +: 4] = state_reg.seq_pos;
                read_word[STAT_SEQ_LSB +: 3] = state_reg.seq_sel;
                read_word[STAT_TX_LED_BIT] = ind_tx;
                read_word[STAT_IDLE_LED_BIT] = ind_idle;
            end
            default: begin
                // unmapped address answers with an error
                mapped = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;

        // speakerphone state follows the comparator; code 11 is held
        // the test bits never enter this path
        case (comparator_mode)
            2'b00: state_next.mode = SP_RX;
            2'b01: state_next.mode = SP_TX;
            2'b10: state_next.mode = SP_IDLE;
            default: state_next.mode = state_reg.mode;
        endcase

        // apb: answer one cycle after the access phase starts
        if (setup_done) begin
            state_next.pready = 1'b1;
            state_next.pslverr = !mapped;
            state_next.prdata = pwrite ? 32'h0000_0000 : read_word;
        end else begin
            state_next.pready = 1'b0;
            state_next.pslverr = 1'b0;
            state_next.prdata = 32'h0000_0000;
        end

        // writes take effect at the completing edge only
        if (complete && pwrite && mapped) begin
            case (paddr)
                CTRL_OFFSET: begin
                    state_next.sp_en = pwdata[CTRL_SP_EN_BIT];
                    state_next.rx_hp_dis = pwdata[CTRL_RX_HP_DIS_BIT];
                    state_next.tx_hp_dis = pwdata[CTRL_TX_HP_DIS_BIT];
                    state_next.pz_test_en = pwdata[CTRL_PZ_TEST_BIT];
                    state_next.test_sel = pwdata[CTRL_TEST_SEL_BIT];
                end
                SEQ_CMD_OFFSET: begin
                    // a new command aborts the running one; stored bytes stay
                    if (pwdata[2:0] < SEQ_COUNT) begin
                        state_next.seq_sel = pwdata[2:0];
                        state_next.seq_pos = 4'h0;
                    end else begin
                        // unknown sequence: nothing accepted until a valid command
                        state_next.seq_pos = SEQ_BYTES;
                    end
                end
                SEQ_DATA_OFFSET: begin
                    // byte position selects the parameter
                    if (state_reg.seq_pos < SEQ_BYTES) begin
                        // don't-care positions are skipped, content ignored
                        if (USED_POS_MASK[byte_index]) begin
                            // stored at once, so it is live on arrival
                            state_next.params[byte_index] = pwdata[7:0];
                        end
                        state_next.seq_pos = state_reg.seq_pos + 4'h1;
                    end
                end
                PARAM_SEL_OFFSET: begin
                    state_next.param_sel = pwdata[5:0];
                end
                default: begin
                    // read-only registers ignore writes
                end
            endcase
        end
    end

    // register the state
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg.pready <= 1'b0;
            state_reg.pslverr <= 1'b0;
            state_reg.prdata <= 32'h0000_0000;
            state_reg.sp_en <= 1'b0;
            state_reg.rx_hp_dis <= 1'b0;
            state_reg.tx_hp_dis <= 1'b0;
            state_reg.pz_test_en <= 1'b0;
            state_reg.test_sel <= 1'b0;
            state_reg.seq_sel <= SEQ_FIRST;
            state_reg.seq_pos <= SEQ_BYTES;
            state_reg.param_sel <= 6'h00;
            state_reg.params <= {48{PARAM_RESET}};
            state_reg.mode <= SP_RX;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // apb outputs
    // ------------------------------------------------------------
    assign prdata = state_reg.prdata;
    assign pready = state_reg.pready;
    assign pslverr = state_reg.pslverr;

    // ------------------------------------------------------------
    // gain stages: switched on with the speakerphone
    // ------------------------------------------------------------
    assign tx_agc_gain_stage_on = state_reg.sp_en;
    assign rx_agc_gain_stage_on = state_reg.sp_en;
    assign tx_agc_gain_stage = state_reg.params[{SEQ_TX_AGC, 3'h0}];
    assign rx_agc_gain_stage = state_reg.params[{SEQ_RX_AGC, 3'h0}];

    // ------------------------------------------------------------
    // first sequence parameters, live from the stored bytes
    // ------------------------------------------------------------
    assign acoustic_echo_gain = state_reg.params[0];
    assign line_echo_gain = state_reg.params[1];
    // a zero third byte is a 0 dB attenuation code, independent of the rest
    assign switchable_attenuation = state_reg.params[2];
    assign acoustic_echo_time = state_reg.params[3];
    assign line_echo_time = state_reg.params[4];
    assign wait_time = state_reg.params[5];
    assign decay_speed = state_reg.params[6];
    assign switching_time = state_reg.params[7];

    // ------------------------------------------------------------
    // test indicators on the piezo pins
    // ------------------------------------------------------------
    test_indicator u_indicator (
        .clk(clk),
        .rst(rst),
        .piezo_test_enable(state_reg.pz_test_en),
        .test_mode_select(state_reg.test_sel),
        .mode_next(state_next.mode),
        .tx_led(ind_tx),
        .idle_led(ind_idle)
    );

    assign piezo_driver_pin_tx = ind_tx;
    assign piezo_driver_pin_idle = ind_idle;

    // ------------------------------------------------------------
    // high-pass filters on both sample paths
    // ------------------------------------------------------------
    sample_if tx_raw ();
    sample_if tx_out ();
    sample_if rx_raw ();
    sample_if rx_out ();

    assign tx_raw.valid = tx_sample_valid;
    assign tx_raw.data = tx_sample_in;
    assign rx_raw.valid = rx_sample_valid;
    assign rx_raw.data = rx_sample_in;

    // transmit filter runs while its disable bit is clear
    highpass_filter u_tx_hp (
        .clk(clk),
        .rst(rst),
        .bypass(state_reg.tx_hp_dis),
        .in_s(tx_raw),
        .out_s(tx_out)
    );

    // receive filter runs while its disable bit is clear
    highpass_filter u_rx_hp (
        .clk(clk),
        .rst(rst),
        .bypass(state_reg.rx_hp_dis),
        .in_s(rx_raw),
        .out_s(rx_out)
    );

    assign tx_filtered_valid = tx_out.valid;
    assign tx_filtered = tx_out.data;
    assign rx_filtered_valid = rx_out.valid;
    assign rx_filtered = rx_out.data;

endmodule // speakerphone_param_load_and_test

// ### bench/spk_asserts.sv
// checker: port-level assertions of the speakerphone control block
`timescale 1ns/1ps
module spk_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [1:0] comparator_mode,
    input wire logic piezo_driver_pin_tx,
    input wire logic piezo_driver_pin_idle,
    input wire logic tx_agc_gain_stage_on,
    input wire logic tx_sample_valid,
    input wire logic [15:0] tx_sample_in,
    input wire logic [15:0] tx_filtered
);
    import spk_pkg::*;
    logic [4:0] ctrl_q; // control bits as last written
    logic on; // test indication enabled
    assign on = ctrl_q[CTRL_PZ_TEST_BIT] & ctrl_q[CTRL_TEST_SEL_BIT];
    // mirror control writes at the completing edge
    always_ff @(posedge clk) begin
        if (rst)
            ctrl_q <= 5'h00;
        else if (psel && penable && pready && pwrite && paddr == CTRL_OFFSET)
            ctrl_q <= pwdata[4:0];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    test_gate_a: assert property (!on |=> !piezo_driver_pin_tx && !piezo_driver_pin_idle)
        else $error("indicator lit with test mode off");
    tx_shown_a: assert property (on && comparator_mode == 2'b01 |=>
        piezo_driver_pin_tx && !piezo_driver_pin_idle) else $error("transmit indication wrong");
    rx_shown_a: assert property (on && comparator_mode == 2'b00 |=>
        !piezo_driver_pin_tx && !piezo_driver_pin_idle) else $error("receive indication wrong");
    idle_hold_a: assert property (on && $past(on) && comparator_mode == 2'b10 |=>
        piezo_driver_pin_idle && piezo_driver_pin_tx == $past(piezo_driver_pin_tx)) else $error("idle indication wrong");
    gain_follow_a: assert property (ctrl_q[0] == $past(ctrl_q[0]) |->
        tx_agc_gain_stage_on == ctrl_q[0]) else $error("gain stage not following enable");
    apb_answer_a: assert property (psel && penable && !pready |=> pready) else $error("apb answer late");
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
    err_map_a: assert property (psel && penable && !pready && paddr[1:0] == 2'b00 |=>
        pready && pslverr == ($past(paddr) > STATUS_OFFSET)) else $error("slave error mismatch");
    bypass_a: assert property (ctrl_q[CTRL_TX_HP_DIS_BIT] && tx_sample_valid |=>
        tx_filtered == $past(tx_sample_in)) else $error("disabled filter altered sample");
    cover property (on && comparator_mode == 2'b10);
    cover property (pready && pslverr);
    cover property (tx_sample_valid && !ctrl_q[CTRL_TX_HP_DIS_BIT]);
endmodule // spk_asserts
bind speakerphone_param_load_and_test spk_asserts u_asserts (.clk, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .pslverr, .comparator_mode, .piezo_driver_pin_tx, .piezo_driver_pin_idle,
    .tx_agc_gain_stage_on, .tx_sample_valid, .tx_sample_in, .tx_filtered);

// ### bench/host_model.sv
// host model: apb master sending register accesses and parameter sequences
`timescale 1ns/1ps
module host_model (
    input wire logic clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    import spk_pkg::*;
    logic [31:0] rdata; // data of the last transfer, zero after a write
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // one transfer: setup, access, hold until pready
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            speakerphone_param_load_and_test_tb.bad_count++;
            speakerphone_param_load_and_test_tb.final_report();
        end
        rdata = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // start a sequence, then n bytes in position order, first byte lowest
    task automatic load(input logic [2:0] s, input int n, input logic [63:0] b);
        xfer(1'b1, SEQ_CMD_OFFSET, {29'h0, s});
        for (int i = 0; i < n; i++)
            xfer(1'b1, SEQ_DATA_OFFSET, {24'h0, b[i*8 +: 8]});
    endtask
endmodule // host_model

// ### bench/speakerphone_param_load_and_test_tb.sv
// testbench: sequences, filters, gain stages and indicators of the speakerphone block
`timescale 1ns/1ps
module speakerphone_param_load_and_test_tb;
    import spk_pkg::*;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, tx_sample_valid, rx_sample_valid;
    logic tx_agc_gain_stage_on, rx_agc_gain_stage_on, piezo_driver_pin_tx, piezo_driver_pin_idle;
    logic tx_filtered_valid, rx_filtered_valid;
    logic [1:0] comparator_mode;
    logic [7:0] paddr, tx_agc_gain_stage, rx_agc_gain_stage;
    logic [7:0] p0 [8]; // first sequence outputs by position
    logic [15:0] tx_sample_in, rx_sample_in, tx_filtered, rx_filtered;
    logic [31:0] pwdata, prdata;
    logic [3:0] walk [5] = '{4'h6, 4'hb, 4'h0, 4'h9, 4'hd}; // mode, tx led, idle led
    logic [15:0] fin [3] = '{16'h1000, 16'h1000, 16'h8001}; // filter inputs
    logic [15:0] fout [3] = '{16'h1000, 16'h0ff0, 16'h8001}; // expected filter outputs
    int bad_count, samples_checked;
    speakerphone_param_load_and_test DUT (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .comparator_mode, .piezo_driver_pin_tx, .piezo_driver_pin_idle, .tx_agc_gain_stage_on,
        .rx_agc_gain_stage_on, .tx_agc_gain_stage, .rx_agc_gain_stage, .acoustic_echo_gain(p0[0]),
        .line_echo_gain(p0[1]), .switchable_attenuation(p0[2]), .acoustic_echo_time(p0[3]),
        .line_echo_time(p0[4]), .wait_time(p0[5]), .decay_speed(p0[6]), .switching_time(p0[7]), .tx_sample_valid,
        .tx_sample_in, .tx_filtered_valid, .tx_filtered, .rx_sample_valid, .rx_sample_in, .rx_filtered_valid,
        .rx_filtered);
    host_model host (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string name);
        host.xfer(1'b0, a, 32'h0);
        chk(name, host.rdata, exp);
    endtask
    task automatic settle();
        repeat (2) @(negedge clk);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        {rst, tx_sample_valid, rx_sample_valid, comparator_mode, tx_sample_in, rx_sample_in} = {1'b1, 36'h0};
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rdc(STATUS_OFFSET, 32'h20, "status_reset");
        // dc removal first, then bypass
        for (int i = 0; i < 3; i++) begin
            if (i == 2)
                host.xfer(1'b1, CTRL_OFFSET, 32'h6);
            @(posedge clk);
            {tx_sample_valid, rx_sample_valid, tx_sample_in, rx_sample_in} <= {2'b11, fin[i], fin[i]};
            @(posedge clk);
            {tx_sample_valid, rx_sample_valid} <= 2'b00;
            @(negedge clk);
            chk("tx_filtered", {tx_filtered_valid, tx_filtered}, {1'b1, fout[i]});
            chk("rx_filtered", {rx_filtered_valid, rx_filtered}, {1'b1, fout[i]});
        end
        // full sequence, then an aborted one with zero attenuation
        host.load(SEQ_FIRST, 8, 64'h8877665544332211);
        settle();
        foreach (p0[i]) chk("first_seq", p0[i], 8'h11 * (i + 1));
        host.load(SEQ_FIRST, 3, 64'h0055a1);
        settle();
        chk("echo_gain", p0[0], 8'ha1);
        chk("attenuation", p0[2], 8'h00);
        chk("echo_time", p0[3], 8'h44);
        rdc(STATUS_OFFSET, 32'h0c, "status_pos");
        host.load(SEQ_TX_AGC, 1, 64'h3c);
        host.load(SEQ_RX_AGC, 8, 64'hee00000000000077);
        settle();
        chk("agc_stages", {tx_agc_gain_stage, rx_agc_gain_stage}, 16'h3c77);
        host.xfer(1'b1, PARAM_SEL_OFFSET, 32'd47);
        rdc(PARAM_DATA_OFFSET, 32'h0, "dont_care");
        host.xfer(1'b1, CTRL_OFFSET, 32'h1);
        settle();
        chk("gain_on", {tx_agc_gain_stage_on, rx_agc_gain_stage_on}, 2'b11);
        host.xfer(1'b0, 8'h20, 32'h0);
        // indicator walk with test active, then with one enable bit only
        for (int k = 0; k < 2; k++) begin
            host.xfer(1'b1, CTRL_OFFSET, k == 0 ? 32'h18 : 32'h08);
            for (int i = 0; i < 5; i++) begin
                @(posedge clk);
                comparator_mode <= walk[i][3:2];
                settle();
                chk("tx_led", piezo_driver_pin_tx, walk[i][1] & (k == 0));
                chk("idle_led", piezo_driver_pin_idle, walk[i][0] & (k == 0));
                rdc(STATUS_OFFSET, {21'h0, walk[i][0] & (k == 0), walk[i][1] & (k == 0), SEQ_RX_AGC, SEQ_BYTES,
                    walk[i][3:2] & {1'b1, ~walk[i][3]}}, "mode");
            end
        end
        final_report();
    end
endmodule // speakerphone_param_load_and_test_tb
